// [alt_pkg.sv]
// Constants, types and register map of the analog level trigger
package alt_pkg;

    localparam int          ALT_DATA_W   = 16;
    localparam int          ALT_CHANNELS = 4;
    localparam int          ALT_CHAN_W   = 2;
    localparam int          ALT_LINES    = 7;
    localparam int          ALT_TSIGS    = 8;
    localparam int          ALT_TSEL_W   = 3;

    // Register byte addresses
    localparam logic [7:0]  ALT_OFF_CTRL   = 8'h00;
    localparam logic [7:0]  ALT_OFF_LOWER  = 8'h04;
    localparam logic [7:0]  ALT_OFF_UPPER  = 8'h08;
    localparam logic [7:0]  ALT_OFF_SWTRIG = 8'h0C;
    localparam logic [7:0]  ALT_OFF_STATUS = 8'h10;
    localparam logic [7:0]  ALT_OFF_BUSDRV = 8'h14;
    localparam logic [7:0]  ALT_OFF_BUSSEL = 8'h18;
    localparam logic [7:0]  ALT_OFF_SECSEL = 8'h1C;

    // Control register fields
    localparam int          ALT_CTRL_ARM      = 0;
    localparam int          ALT_CTRL_MODE_LO  = 1;
    localparam int          ALT_CTRL_CHAN_LO  = 4;
    localparam int          ALT_CTRL_EXT_POL  = 6;
    localparam int          ALT_CTRL_EXT_EDGE = 7;
    localparam int          ALT_CTRL_EXT_BUS  = 8;
    localparam int          ALT_CTRL_EXT_LINE = 9;
    localparam int          ALT_CTRL_ST_LVL   = 12;
    localparam int          ALT_CTRL_ST_SW    = 13;
    localparam int          ALT_CTRL_ST_EXT   = 14;
    localparam int          ALT_CTRL_W        = 15;

    // Status register fields
    localparam int          ALT_STAT_HARM   = 0;
    localparam int          ALT_STAT_FIRED  = 1;
    localparam int          ALT_STAT_EXT    = 2;
    localparam int          ALT_STAT_SAMP   = 16;

    // Internal timing signal indices
    localparam int          ALT_TS_LEVEL = 0;
    localparam int          ALT_TS_SW    = 1;
    localparam int          ALT_TS_EXT   = 2;
    localparam int          ALT_TS_START = 3;
    localparam int          ALT_TS_PART  = 4;
    localparam int          ALT_PART_W   = 4;

    // Section source codes
    localparam logic [1:0]  ALT_SRC_START = 2'h0;
    localparam logic [1:0]  ALT_SRC_LEVEL = 2'h1;
    localparam logic [1:0]  ALT_SRC_SW    = 2'h2;
    localparam logic [1:0]  ALT_SRC_EXT   = 2'h3;
    localparam int          ALT_SECTIONS  = 3;

    localparam logic [31:0] ALT_CTRL_RST   = 32'h0000_0000;
    localparam logic [15:0] ALT_LOWER_RST  = 16'h0000;
    localparam logic [15:0] ALT_UPPER_RST  = 16'h0000;

    typedef enum logic [2:0] {
        MODE_BELOW,
        MODE_ABOVE,
        MODE_INSIDE,
        MODE_HYST_HIGH,
        MODE_HYST_LOW
    } alt_mode_type;

    typedef struct packed {
        logic                                      valid;
        logic [ALT_CHANNELS-1:0][ALT_DATA_W-1:0]   data;
    } alt_sample_type;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } alt_apb_req_type;

endpackage

// [alt_bus_line.sv]
// One bidirectional inter-device timing bus line
`timescale 1ns/1ps
module alt_bus_line
    import alt_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Configuration
    input  wire logic                  drive,
    input  wire logic [ALT_TSEL_W-1:0] sel,
    input  wire logic [ALT_TSIGS-1:0]  tsig,
    // Pin
    input  wire logic                  line_in,
    output logic                       line_out,
    output logic                       line_oe_n,
    // Received level
    output logic                       rx
);

    logic sync_a;

    // Driven value registered so the pin never glitches
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            line_out  <= 1'b0;
            line_oe_n <= 1'b1;
        end else begin
            line_out  <= tsig[sel];
            line_oe_n <= ~drive;
        end
    end

    // Two-stage synchroniser on the received level
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sync_a <= 1'b0;
            rx     <= 1'b0;
        end else begin
            sync_a <= line_in;
            rx     <= sync_a;
        end
    end

endmodule

// [alt_trigger.sv]
// Level, software and external trigger unit with APB registers
// Functional notes
// - one channel selected as level source
// - source channel data path left untouched
// - full 16-bit threshold versus 16-bit sample
// - samples and thresholds compared as signed
// - threshold step equals one sample code
// - evaluate only on sample strobe cycles
// - level trigger selectable by every section
// - five modes, independent lower and upper
// - below-low fires when sample below lower
// - above-high fires when sample above upper
// - inside-region fires between both thresholds
// - high-hysteresis fires above upper threshold
// - low-hysteresis fires below lower threshold
// - timing uncertainty at most one sample
// - software and external triggers start acquisition
// - external trigger polarity and sense programmable
// - external trigger shared over timing bus
// - seven lines drive or receive eight signals
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module alt_trigger
    import alt_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // APB slave
    input  wire alt_apb_req_type       apb_req,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Converter samples
    input  wire alt_sample_type        sample,
    // External trigger pin
    input  wire logic                  ext_trig_pin,
    // Timing signals from the partner sections
    input  wire logic [ALT_PART_W-1:0] partner_timing,
    // Inter-device timing bus
    input  wire logic [ALT_LINES-1:0]  bus_in,
    output logic [ALT_LINES-1:0]       bus_out,
    output logic [ALT_LINES-1:0]       bus_oe_n,
    output logic [ALT_LINES-1:0]       bus_rx,
    // Triggers to the timing sections
    output logic                       level_trig,
    output logic                       start_trig,
    output logic                       ai_trig,
    output logic                       ao_trig,
    output logic                       ctr_trig
);

    logic [ALT_CTRL_W-1:0]             ctrl;
    logic signed [ALT_DATA_W-1:0]      lower_threshold;
    logic signed [ALT_DATA_W-1:0]      upper_threshold;
    logic [ALT_LINES-1:0]              bus_drive;
    logic [ALT_LINES*ALT_TSEL_W-1:0]   bus_sel;
    logic [2*ALT_SECTIONS-1:0]         sec_sel;
    logic                              sw_trig;
    logic                              hyst_armed;
    logic                              fired;
    logic signed [ALT_DATA_W-1:0]      last_sample;
    logic                              ext_sync_a;
    logic                              ext_sync_b;
    logic                              ext_prev;
    logic                              ext_trig;
    logic [ALT_TSIGS-1:0]              tsig;
    logic                              wr_en;
    logic                              rd_en;
    logic                              addr_ok;
    logic [31:0]                       next_rdata;
    logic signed [ALT_DATA_W-1:0]      src_sample;
    logic                              below;
    logic                              above;
    logic                              hit;
    logic                              ext_level;
    logic                              ext_raw;
    logic                              next_ext_trig;
    logic [ALT_TSEL_W-1:0]             ext_line;
    alt_mode_type                      mode;

    assign mode     = alt_mode_type'(ctrl[ALT_CTRL_MODE_LO +: 3]);
    assign ext_line = ctrl[ALT_CTRL_EXT_LINE +: ALT_TSEL_W];

    // APB decode, zero wait states
    assign wr_en  = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign rd_en  = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
    assign pready = apb_req.psel & apb_req.penable;

    always_comb begin
        unique case (apb_req.paddr)
            ALT_OFF_CTRL, ALT_OFF_LOWER, ALT_OFF_UPPER, ALT_OFF_SWTRIG,
            ALT_OFF_STATUS, ALT_OFF_BUSDRV, ALT_OFF_BUSSEL,
            ALT_OFF_SECSEL: addr_ok = 1'b1;
            default:        addr_ok = 1'b0;
        endcase
    end

    assign pslverr = pready & ~addr_ok;

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (apb_req.paddr)
            ALT_OFF_CTRL:
                next_rdata[ALT_CTRL_W-1:0] = ctrl;
            ALT_OFF_LOWER:
                next_rdata[ALT_DATA_W-1:0] = lower_threshold;
            ALT_OFF_UPPER:
                next_rdata[ALT_DATA_W-1:0] = upper_threshold;
            ALT_OFF_STATUS: begin
                next_rdata[ALT_STAT_HARM]  = hyst_armed;
                next_rdata[ALT_STAT_FIRED] = fired;
                next_rdata[ALT_STAT_EXT]   = ext_level;
                next_rdata[ALT_STAT_SAMP +: ALT_DATA_W] = last_sample;
            end
            ALT_OFF_BUSDRV:
                next_rdata[ALT_LINES-1:0] = bus_drive;
            ALT_OFF_BUSSEL:
                next_rdata[ALT_LINES*ALT_TSEL_W-1:0] = bus_sel;
            ALT_OFF_SECSEL:
                next_rdata[2*ALT_SECTIONS-1:0] = sec_sel;
            default:
                next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= next_rdata;
        end
    end

    // Configuration registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl            <= ALT_CTRL_RST[ALT_CTRL_W-1:0];
            lower_threshold <= ALT_LOWER_RST;
            upper_threshold <= ALT_UPPER_RST;
            bus_drive       <= '0;
            bus_sel         <= '0;
            sec_sel         <= '0;
        end else if (wr_en) begin
            unique case (apb_req.paddr)
                ALT_OFF_CTRL:
                    ctrl <= apb_req.pwdata[ALT_CTRL_W-1:0];
                ALT_OFF_LOWER:
                    lower_threshold <= apb_req.pwdata[ALT_DATA_W-1:0];
                ALT_OFF_UPPER:
                    upper_threshold <= apb_req.pwdata[ALT_DATA_W-1:0];
                ALT_OFF_BUSDRV:
                    bus_drive <= apb_req.pwdata[ALT_LINES-1:0];
                ALT_OFF_BUSSEL:
                    bus_sel <= apb_req.pwdata[ALT_LINES*ALT_TSEL_W-1:0];
                ALT_OFF_SECSEL:
                    sec_sel <= apb_req.pwdata[2*ALT_SECTIONS-1:0];
                default: ;
            endcase
        end
    end

    // Software trigger command, one-cycle pulse
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sw_trig <= 1'b0;
        end else begin
            sw_trig <= wr_en & (apb_req.paddr == ALT_OFF_SWTRIG)
                       & apb_req.pwdata[0];
        end
    end

    // Tap of the selected channel only; samples pass on unchanged
    assign src_sample =
        sample.data[ctrl[ALT_CTRL_CHAN_LO +: ALT_CHAN_W]];
    assign below = src_sample < lower_threshold;
    assign above = src_sample > upper_threshold;

    always_comb begin
        unique case (mode)
            MODE_BELOW:     hit = below;
            MODE_ABOVE:     hit = above;
            MODE_INSIDE:    hit = ~below & ~above;
            MODE_HYST_HIGH: hit = above & hyst_armed;
            MODE_HYST_LOW:  hit = below & hyst_armed;
            default:        hit = 1'b0;
        endcase
    end

    // Level trigger pulse follows the qualifying strobe by one edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level_trig <= 1'b0;
        end else begin
            level_trig <= sample.valid & hit
                          & ctrl[ALT_CTRL_ARM];
        end
    end

    // Hysteresis arm state, reset while disarmed
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            hyst_armed <= 1'b1;
        end else if (!ctrl[ALT_CTRL_ARM]) begin
            hyst_armed <= 1'b1;
        end else if (sample.valid) begin
            if (mode == MODE_HYST_HIGH) begin
                if (hyst_armed && above) begin
                    hyst_armed <= 1'b0;
                end else if (below) begin
                    hyst_armed <= 1'b1;
                end
            end else if (mode == MODE_HYST_LOW) begin
                if (hyst_armed && below) begin
                    hyst_armed <= 1'b0;
                end else if (above) begin
                    hyst_armed <= 1'b1;
                end
            end else begin
                hyst_armed <= 1'b1;
            end
        end
    end

    // Sticky fired flag, write one to clear; a new pulse wins
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fired <= 1'b0;
        end else if (level_trig) begin
            fired <= 1'b1;
        end else if (wr_en && apb_req.paddr == ALT_OFF_STATUS
                     && apb_req.pwdata[ALT_STAT_FIRED]) begin
            fired <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_sample <= '0;
        end else if (sample.valid) begin
            last_sample <= src_sample;
        end
    end

    // External trigger pin synchroniser
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_sync_a <= 1'b0;
            ext_sync_b <= 1'b0;
        end else begin
            ext_sync_a <= ext_trig_pin;
            ext_sync_b <= ext_sync_a;
        end
    end

    // Pin or a received bus line, then polarity
    always_comb begin
        if (ctrl[ALT_CTRL_EXT_BUS] && ext_line < ALT_TSEL_W'(ALT_LINES)) begin
            ext_raw = bus_rx[ext_line];
        end else begin
            ext_raw = ext_sync_b;
        end
    end

    assign ext_level = ext_raw ^ ctrl[ALT_CTRL_EXT_POL];

    always_comb begin
        if (ctrl[ALT_CTRL_EXT_EDGE]) begin
            next_ext_trig = ext_level & ~ext_prev;
        end else begin
            next_ext_trig = ext_level;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ext_prev <= 1'b0;
            ext_trig <= 1'b0;
        end else begin
            ext_prev <= ext_level;
            ext_trig <= next_ext_trig;
        end
    end

    // Combined start of an acquisition sequence
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            start_trig <= 1'b0;
        end else begin
            start_trig <= (level_trig & ctrl[ALT_CTRL_ST_LVL])
                        | (sw_trig & ctrl[ALT_CTRL_ST_SW])
                        | (ext_trig & ctrl[ALT_CTRL_ST_EXT]);
        end
    end

    // Sources passed as arguments so the assigns follow them
    logic [3:0]                        sec_src;
    assign sec_src[ALT_SRC_START] = start_trig;
    assign sec_src[ALT_SRC_LEVEL] = level_trig;
    assign sec_src[ALT_SRC_SW]    = sw_trig;
    assign sec_src[ALT_SRC_EXT]   = ext_trig;
    function automatic logic pick_src(input logic [1:0] code,
                                      input logic [3:0] srcs);
        pick_src = srcs[code];
    endfunction

    assign ai_trig  = pick_src(sec_sel[1:0], sec_src);
    assign ao_trig  = pick_src(sec_sel[3:2], sec_src);
    assign ctr_trig = pick_src(sec_sel[5:4], sec_src);

    // Eight internal timing signals offered to the bus lines
    assign tsig[ALT_TS_LEVEL] = level_trig;
    assign tsig[ALT_TS_SW]    = sw_trig;
    assign tsig[ALT_TS_EXT]   = ext_trig;
    assign tsig[ALT_TS_START] = start_trig;
    assign tsig[ALT_TS_PART +: ALT_PART_W] = partner_timing;

    genvar gi;
    generate
        for (gi = 0; gi < ALT_LINES; gi++) begin : g_line
            alt_bus_line u_line (
                .mclk      (mclk),
                .rst       (rst),
                .drive     (bus_drive[gi]),
                .sel       (bus_sel[gi*ALT_TSEL_W +: ALT_TSEL_W]),
                .tsig      (tsig),
                .line_in   (bus_in[gi]),
                .line_out  (bus_out[gi]),
                .line_oe_n (bus_oe_n[gi]),
                .rx        (bus_rx[gi])
            );
        end
    endgenerate

endmodule

// [alt_trigger_chk.sv]
// Checker for the level trigger unit ports
`timescale 1ns/1ps
module alt_trigger_chk
    import alt_pkg::*;
(
    // Clock and reset
    input wire logic            mclk,
    input wire logic            rst,
    // Watched ports
    input wire alt_apb_req_type apb_req,
    input wire alt_sample_type  sample,
    input wire logic            level_trig,
    input wire logic            start_trig
);
    logic [14:0]        ctrl;
    logic signed [15:0] lo;
    logic signed [15:0] hi;
    logic signed [15:0] s;
    logic [2:0]         mode;
    logic               harm;
    logic               next_harm;
    logic               wr;
    logic               stb;
    logic               lt;
    logic               gt;

    assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    assign mode = ctrl[3:1];
    assign s = sample.data[ctrl[5:4]];
    assign stb = sample.valid & ctrl[0];
    assign lt = s < lo;
    assign gt = s > hi;
    assign next_harm = (mode == 3'h3) ? (harm ? !gt : lt)
                                      : (harm ? !lt : gt);

    // Shadow of the configuration writes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl <= '0;
            lo <= '0;
            hi <= '0;
        end else if (wr) begin
            if (apb_req.paddr == ALT_OFF_CTRL) begin
                ctrl <= apb_req.pwdata[14:0];
            end
            if (apb_req.paddr == ALT_OFF_LOWER) begin
                lo <= apb_req.pwdata[15:0];
            end
            if (apb_req.paddr == ALT_OFF_UPPER) begin
                hi <= apb_req.pwdata[15:0];
            end
        end
    end

    // Hysteresis state, held set outside the hysteresis modes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            harm <= 1'b1;
        end else if (!ctrl[0] || mode < 3'h3 || mode > 3'h4) begin
            harm <= 1'b1;
        end else if (sample.valid) begin
            harm <= next_harm;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    AST_BELOW: assert property (stb && mode == 3'h0 |=>
        level_trig == $past(lt))
        else $error("below-low trigger wrong");
    AST_ABOVE: assert property (stb && mode == 3'h1 |=>
        level_trig == $past(gt))
        else $error("above-high trigger wrong");
    AST_INSIDE: assert property (stb && mode == 3'h2 |=>
        level_trig == (!$past(lt) && !$past(gt)))
        else $error("inside-region trigger wrong");
    AST_HYST_HIGH: assert property (stb && mode == 3'h3 |=>
        level_trig == ($past(harm) && $past(gt)))
        else $error("high hysteresis trigger wrong");
    AST_HYST_LOW: assert property (stb && mode == 3'h4 |=>
        level_trig == ($past(harm) && $past(lt)))
        else $error("low hysteresis trigger wrong");
    AST_SPARE_MODE: assert property (stb && mode > 3'h4 |=>
        !level_trig)
        else $error("trigger in undefined mode");
    AST_DISARMED: assert property (sample.valid && !ctrl[0] |=>
        !level_trig)
        else $error("trigger while disarmed");
    AST_STROBE_ONLY: assert property (!sample.valid |=>
        !level_trig)
        else $error("trigger without sample strobe");
    AST_START_LEVEL: assert property (level_trig && ctrl[12] |=>
        start_trig)
        else $error("start missing after level trigger");
endmodule

bind alt_trigger alt_trigger_chk u_chk (
    .mclk       (mclk),
    .rst        (rst),
    .apb_req    (apb_req),
    .sample     (sample),
    .level_trig (level_trig),
    .start_trig (start_trig)
);

// [alt_conv_model.sv]
// Converter sample source feeding the trigger unit
`timescale 1ns/1ps
module alt_conv_model
    import alt_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // Request from the bench
    input  wire logic                  go,
    input  wire logic [ALT_CHAN_W-1:0] chan,
    input  wire logic [ALT_DATA_W-1:0] value,
    // Converter output
    output alt_sample_type             sample
);
    // Strobe marks the filtered output, filter delay already spent
    // Other channels carry the inverse, idle data toggles
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sample <= '0;
        end else begin
            sample.valid <= go;
            for (int i = 0; i < ALT_CHANNELS; i++) begin
                if (go && i == int'(chan)) begin
                    sample.data[i] <= value;
                end else if (go) begin
                    sample.data[i] <= ~value;
                end else begin
                    sample.data[i] <= ~sample.data[i];
                end
            end
        end
    end
endmodule

// [analog_level_trigger_tb.sv]
// Self-checking bench of the level trigger unit
`timescale 1ns/1ps
module analog_level_trigger_tb;
    import alt_pkg::*;
    logic            mclk;
    logic            rst;
    alt_apb_req_type req;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
    alt_sample_type  smp;
    logic            ext_pin;
    logic [6:0]      bus_lvl;
    logic [6:0]      bus_in;
    logic [6:0]      bus_out;
    logic [6:0]      bus_oe_n;
    logic [6:0]      bus_rx;
    logic            level_trig;
    logic            start_trig;
    logic            ai_trig;
    logic            ao_trig;
    logic            ctr_trig;
    logic            go;
    logic [15:0]     val;
    logic [31:0]     rdat;
    logic            rerr;
    int              n_mismatch;
    int              total_checks;
    int              cnt;
    logic [15:0]     smp_tab [9] = '{16'hFF38, 16'h0000, 16'h00C8,
        16'h0096, 16'h0000, 16'hFF38, 16'hFF6A, 16'h0064, 16'hFF9C};
    logic [8:0]      fire_tab [6] = '{9'h10C, 9'h060, 9'h093,
        9'h040, 9'h108, 9'h000};

    // Undriven lines show the other device's level
    assign bus_in = (bus_out & ~bus_oe_n) | (bus_lvl & bus_oe_n);

    alt_trigger dut (
        .mclk(mclk), .rst(rst), .apb_req(req), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample(smp),
        .ext_trig_pin(ext_pin), .partner_timing(4'h0),
        .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n),
        .bus_rx(bus_rx), .level_trig(level_trig),
        .start_trig(start_trig), .ai_trig(ai_trig),
        .ao_trig(ao_trig), .ctr_trig(ctr_trig)
    );

    alt_conv_model conv (
        .mclk(mclk), .rst(rst), .go(go), .chan(2'h2),
        .value(val), .sample(smp)
    );

    always #2 mclk = ~mclk;

    task automatic close_out();
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge mclk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge mclk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdat = prdata;
        rerr = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_mismatch++;
            close_out();
        end
    endtask

    task automatic strobe(input logic [15:0] v, input logic f);
        @(posedge mclk);
        go <= 1'b1;
        val <= v;
        @(posedge mclk);
        go <= 1'b0;
        @(posedge mclk);
        @(negedge mclk);
        check(level_trig, f);
        check({ai_trig, ao_trig, ctr_trig}, {3{f}});
        @(negedge mclk);
        check({level_trig, start_trig}, {1'b0, f});
    endtask

    task automatic count(input int c);
        cnt = 0;
        repeat (c) begin
            @(posedge mclk);
            if (start_trig === 1'b1) begin
                cnt++;
            end
        end
    endtask

    initial begin
        mclk = 0;
        rst = 1;
        req = '0;
        go = 0;
        val = '0;
        ext_pin = 0;
        bus_lvl = '0;
        n_mismatch = 0;
        total_checks = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        apb(0, ALT_OFF_CTRL, 0);
        check(rdat, ALT_CTRL_RST);
        apb(0, 8'h20, 0);
        check(rerr, 1'b1);
        check(rdat, 32'h0);
        apb(1, ALT_OFF_LOWER, 32'h8001);
        apb(1, ALT_OFF_UPPER, 32'h7FFE);
        apb(0, ALT_OFF_LOWER, 0);
        check(rdat, 32'h8001);
        apb(0, ALT_OFF_UPPER, 0);
        check(rdat, 32'h7FFE);
        apb(1, ALT_OFF_LOWER, 32'hFF9C);
        apb(1, ALT_OFF_UPPER, 32'h0064);
        apb(1, ALT_OFF_SECSEL, 32'h15);
        apb(1, ALT_OFF_CTRL, 32'h1020);
        strobe(16'hFF38, 1'b0);
        for (int m = 0; m < 6; m++) begin
            apb(1, ALT_OFF_CTRL, 32'h1020);
            apb(1, ALT_OFF_CTRL, 32'h1021 | (m << 1));
            for (int k = 0; k < 9; k++) begin
                strobe(smp_tab[k], fire_tab[m][8-k]);
            end
        end
        apb(0, ALT_OFF_STATUS, 0);
        check(rdat, 32'hFF9C_0003);
        apb(1, ALT_OFF_STATUS, 32'h2);
        apb(0, ALT_OFF_STATUS, 0);
        check(rdat[1], 1'b0);
        apb(1, ALT_OFF_CTRL, 32'h2000);
        apb(1, ALT_OFF_SWTRIG, 32'h1);
        count(6);
        check(cnt, 1);
        apb(1, ALT_OFF_CTRL, 32'h4080);
        ext_pin <= 1'b1;
        count(8);
        check(cnt, 1);
        apb(1, ALT_OFF_CTRL, 32'h40C0);
        count(8);
        check(cnt, 0);
        ext_pin <= 1'b0;
        count(8);
        check(cnt, 1);
        apb(1, ALT_OFF_CTRL, 32'h0040);
        apb(1, ALT_OFF_BUSDRV, 32'h01);
        apb(1, ALT_OFF_BUSSEL, 32'h2);
        apb(1, ALT_OFF_SECSEL, 32'h38);
        apb(0, ALT_OFF_STATUS, 0);
        check(rdat[2], 1'b1);
        check({ai_trig, ao_trig, ctr_trig}, 3'b001);
        check({bus_oe_n, bus_out[0]}, 8'hFD);
        apb(1, ALT_OFF_CTRL, 32'h0700);
        bus_lvl[3] <= 1'b1;
        repeat (6) @(posedge mclk);
        check(bus_rx[3], 1'b1);
        apb(0, ALT_OFF_STATUS, 0);
        check(rdat[2], 1'b1);
        close_out();
    end
endmodule
